// *** common/fmid_pkg.sv ***
// Purpose: shared constants and carriers for the power-down and id block
// Assumes: 100 MHz system clock, link clock from the host
// Notes:   identity values live as parameters of the top module
package fmid_pkg;

  // ------------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam logic [7:0] OP_MFR_DEV = 8'h90;
  localparam logic [7:0] OP_MFR_DEV_DUAL = 8'h92;
  localparam logic [7:0] OP_UNIQUE = 8'h4b;
  localparam logic [7:0] OP_JEDEC = 8'h9f;

  // ------------------------------------------------------------------
  // link clock counts (rising edges since select fell), plus the last jedec stream index
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_BITS = 8'h08;
  localparam logic [7:0] CLK_SAT = 8'hff;
  localparam logic [7:0] START_RES = 8'h20;
  localparam logic [7:0] START_MD = 8'h20;
  localparam logic [7:0] START_MDD = 8'h18;
  localparam logic [7:0] START_UID = 8'h28;
  localparam logic [7:0] START_JID = 8'h08;
  localparam logic [7:0] ADDR_END_MD = 8'h20;
  localparam logic [7:0] ADDR_END_MDD = 8'h14;
  localparam logic [6:0] JID_LAST = 7'h17;

  // ------------------------------------------------------------------
  // timing, times in ns
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_DP_NS = 3000;
  localparam int T_RES1_NS = 3000;
  localparam int T_RES2_NS = 3000;
  localparam int TMR_W = 16;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    K_NONE, K_RES, K_MD, K_MDD, K_UID, K_JID
  } fmid_kind_e;

  typedef enum logic [1:0] {
    ST_RUN, ST_ENTER, ST_DOWN, ST_WAKE
  } fmid_pwr_e;

  // frame summary handed from link to system domain
  typedef struct packed {
    logic tgl;
    logic [7:0] op;
    logic [7:0] clocks;
  } fmid_frame_s;

  // pin drive, bit 1 is io1 (serial out), bit 0 is io0
  typedef struct packed {
    logic [1:0] d;
    logic [1:0] oe;
  } fmid_drive_s;

endpackage : fmid_pkg

// *** rtl/fmid_link_rx.sv ***
// Purpose: link-side opcode decode and id stream generation
// Assumes: host stops the link clock before raising select
// Notes:   gate and busy arrive from the system clock via two flops
`timescale 1ns/100ps
module fmid_link_rx
#(
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [7:0] DEV_ID = 8'h11,
  parameter logic [7:0] MEM_TYPE = 8'h22,
  parameter logic [7:0] CAP_CODE = 8'h33,
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef
)
(
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic io0_i,
  input wire logic io1_i,
  // system domain levels
  input wire logic gate,
  input wire logic busy,
  // results
  output fmid_pkg::fmid_frame_s frame,
  output fmid_pkg::fmid_drive_s drv
);

  typedef struct packed {
    logic gate_s1;
    logic gate_s2;
    logic busy_s1;
    logic busy_s2;
    logic tgl;
    logic [7:0] clocks;
    logic [7:0] sh;
    logic [7:0] op;
    fmid_pkg::fmid_kind_e kind;
    logic a0;
    logic [6:0] oix;
    fmid_pkg::fmid_drive_s drv;
  } fmid_rx_s;

  fmid_rx_s r_ff;
  fmid_rx_s nxt_r;
  logic fresh_ff;
  logic [7:0] c;
  logic [7:0] opc;
  fmid_pkg::fmid_kind_e k;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic fmid_pkg::fmid_kind_e fmid_decode(
    input logic [7:0] op, input logic pd, input logic bz);
    fmid_pkg::fmid_kind_e kd;
    case (op)
      fmid_pkg::OP_RELEASE: kd = bz ? fmid_pkg::K_NONE : fmid_pkg::K_RES;
      fmid_pkg::OP_MFR_DEV: kd = fmid_pkg::K_MD;
      fmid_pkg::OP_MFR_DEV_DUAL: kd = fmid_pkg::K_MDD;
      fmid_pkg::OP_UNIQUE: kd = fmid_pkg::K_UID;
      fmid_pkg::OP_JEDEC: kd = fmid_pkg::K_JID;
      default: kd = fmid_pkg::K_NONE;
    endcase
    if (pd && op != fmid_pkg::OP_RELEASE)
      kd = fmid_pkg::K_NONE;
    return kd;
  endfunction : fmid_decode

  function automatic logic [7:0] fmid_start(input fmid_pkg::fmid_kind_e kd);
    case (kd)
      fmid_pkg::K_RES: return fmid_pkg::START_RES;
      fmid_pkg::K_MD: return fmid_pkg::START_MD;
      fmid_pkg::K_MDD: return fmid_pkg::START_MDD;
      fmid_pkg::K_UID: return fmid_pkg::START_UID;
      default: return fmid_pkg::START_JID;
    endcase
  endfunction : fmid_start

  // bit(s) for stream index ix, msb first, {io1, io0}
  function automatic logic [1:0] fmid_bits(input fmid_pkg::fmid_kind_e kd,
    input logic [6:0] ix, input logic a);
    logic [7:0] byt;
    logic [15:0] w16;
    logic [23:0] w24;
    byt = (ix[3] ^ a) ? DEV_ID : MFR_ID;
    w16 = a ? {DEV_ID, MFR_ID} : {MFR_ID, DEV_ID};
    w24 = {MFR_ID, MEM_TYPE, CAP_CODE};
    case (kd)
      fmid_pkg::K_RES: return {DEV_ID[~ix[2:0]], 1'b0};
      fmid_pkg::K_MD: return {byt[~ix[2:0]], 1'b0};
      fmid_pkg::K_MDD: return w16[{~ix[2:0], 1'b1} -: 2];
      fmid_pkg::K_UID: return {UNIQUE_ID[~ix[5:0]], 1'b0};
      fmid_pkg::K_JID: return {w24[5'd23 - ix[4:0]], 1'b0};
      default: return 2'h0;
    endcase
  endfunction : fmid_bits

  // first rising edge of a frame clears this; deselect presets it
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
      fresh_ff <= 1'b1;
    else
      fresh_ff <= 1'b0;
  end

  // --------------------------------------------------------------
  // decode and stream
  // --------------------------------------------------------------
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.gate_s1 = gate;
    nxt_r.gate_s2 = r_ff.gate_s1;
    nxt_r.busy_s1 = busy;
    nxt_r.busy_s2 = r_ff.busy_s1;
    if (fresh_ff)
      c = 8'h01;
    else if (r_ff.clocks == fmid_pkg::CLK_SAT)
      c = fmid_pkg::CLK_SAT;
    else
      c = r_ff.clocks + 8'h01;
    nxt_r.clocks = c;
    opc = {r_ff.sh[6:0], io0_i};
    k = fresh_ff ? fmid_pkg::K_NONE : r_ff.kind;
    if (fresh_ff)
    begin
      nxt_r.tgl = ~r_ff.tgl;  // tells the system side new data exists
      nxt_r.oix = 7'h00;
      nxt_r.drv = '0;
    end
    if (c <= fmid_pkg::CMD_BITS)
      nxt_r.sh = opc;
    if (c == fmid_pkg::CMD_BITS)
    begin
      nxt_r.op = opc;
      k = fmid_decode(opc, r_ff.gate_s2, r_ff.busy_s2); // RULE3 RULE9
    end
    nxt_r.kind = k;
    // only the last address bit picks the byte order
    if ((k == fmid_pkg::K_MD && c == fmid_pkg::ADDR_END_MD) ||
        (k == fmid_pkg::K_MDD && c == fmid_pkg::ADDR_END_MDD))
      nxt_r.a0 = io0_i; // RULE11
    if (k != fmid_pkg::K_NONE && c >= fmid_start(k))
    begin
      nxt_r.drv.d = fmid_bits(k, nxt_r.oix, nxt_r.a0); // RULE6 RULE10 RULE14
      nxt_r.drv.oe = (k == fmid_pkg::K_MDD) ? 2'h3 : 2'h2; // RULE12
      if (k == fmid_pkg::K_JID && nxt_r.oix == fmid_pkg::JID_LAST)
        nxt_r.oix = 7'h00; // RULE15
      else
        nxt_r.oix = nxt_r.oix + 7'h01; // RULE7
    end
  end

  // io1 is not sampled in dual address phase, only io0 loads a0
  always_ff @(posedge sck or negedge reset_n)
  begin
    if (!reset_n)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  assign frame = '{tgl: r_ff.tgl, op: r_ff.op, clocks: r_ff.clocks};
  assign drv = r_ff.drv;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_pd_filter;
    @(posedge sck) disable iff (!reset_n || cs_n)
    (c == fmid_pkg::CMD_BITS && !fresh_ff && r_ff.gate_s2 &&
     opc != fmid_pkg::OP_RELEASE) |=> r_ff.kind == fmid_pkg::K_NONE;
  endproperty
  a_pd_filter: assert property (p_pd_filter) // RULE3
    else $error("command accepted while powered down");

  property p_busy_res;
    @(posedge sck) disable iff (!reset_n || cs_n)
    (c == fmid_pkg::CMD_BITS && !fresh_ff && r_ff.busy_s2 &&
     opc == fmid_pkg::OP_RELEASE) |=> r_ff.kind == fmid_pkg::K_NONE;
  endproperty
  a_busy_res: assert property (p_busy_res) // RULE9
    else $error("release accepted while busy");

  property p_res_repeat;
    @(posedge sck) disable iff (!reset_n || cs_n)
    (r_ff.kind == fmid_pkg::K_RES && r_ff.oix[2:0] == 3'h1)
      |-> r_ff.drv.d[1] == DEV_ID[7] && r_ff.drv.oe == 2'h2;
  endproperty
  a_res_repeat: assert property (p_res_repeat) // RULE7
    else $error("device id byte not repeated msb first");

  property p_md_swap;
    @(posedge sck) disable iff (!reset_n || cs_n)
    (r_ff.kind == fmid_pkg::K_MD && r_ff.a0 && r_ff.oix == 7'h01)
      |-> r_ff.drv.d[1] == DEV_ID[7] ##8 r_ff.drv.d[1] == MFR_ID[7];
  endproperty
  a_md_swap: assert property (p_md_swap) // RULE11
    else $error("address one did not swap id order");

  property p_dual_pair;
    @(posedge sck) disable iff (!reset_n || cs_n)
    (r_ff.kind == fmid_pkg::K_MDD && !r_ff.a0 && r_ff.oix == 7'h01)
      |-> r_ff.drv.d == MFR_ID[7:6] && r_ff.drv.oe == 2'h3;
  endproperty
  a_dual_pair: assert property (p_dual_pair) // RULE12
    else $error("dual id read wrong first pair");

  property p_jedec_order;
    @(posedge sck) disable iff (!reset_n || cs_n)
    (r_ff.kind == fmid_pkg::K_JID && r_ff.oix == 7'h01)
      |-> r_ff.drv.d[1] == MFR_ID[7] ##8 r_ff.drv.d[1] == MEM_TYPE[7]
      ##8 r_ff.drv.d[1] == CAP_CODE[7];
  endproperty
  a_jedec_order: assert property (p_jedec_order) // RULE15
    else $error("jedec id bytes out of order");

  c_dual: cover property (@(posedge sck) r_ff.kind == fmid_pkg::K_MDD
    && r_ff.oix == 7'h08);
  c_uid: cover property (@(posedge sck) r_ff.kind == fmid_pkg::K_UID
    && r_ff.oix == 7'h40);

endmodule : fmid_link_rx

// *** rtl/fmid_link_tx.sv ***
// Purpose: output stage, launches data on the falling link clock
// Assumes: select high releases the pins at once
// Notes:   data is precomputed on the rising edge by the receiver
`timescale 1ns/100ps
module fmid_link_tx
(
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic reset_n,
  // from receiver
  input wire fmid_pkg::fmid_drive_s drv_in,
  // pins
  output logic io0_o,
  output logic io0_oe,
  output logic io1_o,
  output logic io1_oe
);

  typedef struct packed {
    fmid_pkg::fmid_drive_s drv;
  } fmid_tx_s;

  fmid_tx_s tx_ff;
  fmid_tx_s nxt_tx;
  logic rel_n;

  // deselect or reset lets go of the pins without a clock
  assign rel_n = reset_n & ~cs_n;

  // next state
  always_comb
  begin
    nxt_tx = tx_ff;
    nxt_tx.drv = drv_in;
  end

  // data changes on falling edges, or clears at once on release
  always_ff @(negedge sck or negedge rel_n)
  begin
    if (!rel_n)
      tx_ff <= '0;
    else
      tx_ff <= nxt_tx;
  end

  assign io0_o = tx_ff.drv.d[0];
  assign io1_o = tx_ff.drv.d[1];
  assign io0_oe = tx_ff.drv.oe[0];
  assign io1_oe = tx_ff.drv.oe[1];

endmodule : fmid_link_tx

// *** rtl/fmid_top.sv ***
// Purpose: power-down and identification command handling of a
//          serial flash, system-clock power state plus link datapath
// Assumes: host stops the link clock before raising select
// Notes:   frame results cross on the select edge, see below
// Contract
// [RULE1] power-down executes only if select rises right after eight bits
// [RULE2] power-down state reached within the entry time after select rises; code adds up to three cycles of select sync
// [RULE3] while powered down only the release opcode is recognised
// [RULE4] reset always leaves the device in normal operation
// [RULE5] release alone resumes operation after the release wait time
// [RULE6] release opcode plus three dummy bytes streams device id, msb first
// [RULE7] device id byte repeats until select rises
// [RULE8] release with id readout resumes after the id wait time
// [RULE9] release opcode while busy is ignored, running cycle untouched
// [RULE10] opcode 90h with address zero gives maker byte then device byte
// [RULE11] address one swaps the order; bytes alternate until select rises
// [RULE12] dual form takes address and returns ids two bits per clock
// [RULE13] host drives the mode bits with the upper nibble all ones
// [RULE14] opcode 4Bh after four dummy bytes streams the 64-bit unique number
// [RULE15] opcode 9Fh streams maker, memory type, then capacity code
// [RULE16] busy stays high for the whole program or erase cycle
`timescale 1ns/100ps
module fmid_top
#(
  parameter logic [7:0] MFR_ID = 8'h5a,    // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h11,    // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h22,  // arbitrary value
  parameter logic [7:0] CAP_CODE = 8'h33,  // arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef, // arbitrary
  parameter int T_DP_NS = fmid_pkg::T_DP_NS,
  parameter int T_RES1_NS = fmid_pkg::T_RES1_NS,
  parameter int T_RES2_NS = fmid_pkg::T_RES2_NS
)
(
  // system
  input wire logic clk,
  input wire logic reset_n,
  // serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic io0_i,
  input wire logic io1_i,
  output logic io0_o,
  output logic io0_oe,
  output logic io1_o,
  output logic io1_oe,
  // array cycle events from program and erase logic
  input wire logic cyc_start,
  input wire logic cyc_done,
  // status
  output logic busy,
  output logic powered_down
);

  // ------------------------------------------------------------------
  // timing counts, longest times round down, never below one cycle
  // ------------------------------------------------------------------
  function automatic int fmid_cyc(input int ns);
    int n;
    n = ns / fmid_pkg::CLK_PERIOD_NS;
    return (n < 1) ? 1 : n;
  endfunction : fmid_cyc

  localparam int TDP_CYC = fmid_cyc(T_DP_NS);
  localparam int RES1_CYC = fmid_cyc(T_RES1_NS);
  localparam int RES2_CYC = fmid_cyc(T_RES2_NS);
  localparam int TDP_B = TDP_CYC + 1;
  localparam int RESMAX_B = RES1_CYC + RES2_CYC + 1;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic seen;
    logic busy;
    logic gate;
    fmid_pkg::fmid_pwr_e pwr;
    logic [fmid_pkg::TMR_W-1:0] tmr;
  } fmid_sys_s;

  fmid_sys_s s_ff;
  fmid_sys_s nxt_s;
  fmid_pkg::fmid_frame_s frame;
  fmid_pkg::fmid_drive_s drv;
  logic end_frame;
  logic new_frame;
  logic pd_cmd;
  logic rel_cmd;

  // ------------------------------------------------------------------
  // link datapath
  // ------------------------------------------------------------------
  fmid_link_rx #(
    .MFR_ID(MFR_ID),
    .DEV_ID(DEV_ID),
    .MEM_TYPE(MEM_TYPE),
    .CAP_CODE(CAP_CODE),
    .UNIQUE_ID(UNIQUE_ID)
  ) u_rx (
    .sck(spi_sck),
    .cs_n(spi_cs_n),
    .reset_n(reset_n),
    .io0_i(io0_i),
    .io1_i(io1_i),
    .gate(s_ff.gate),
    .busy(s_ff.busy),
    .frame(frame),
    .drv(drv)
  );

  fmid_link_tx u_tx (
    .sck(spi_sck),
    .cs_n(spi_cs_n),
    .reset_n(reset_n),
    .drv_in(drv),
    .io0_o(io0_o),
    .io0_oe(io0_oe),
    .io1_o(io1_o),
    .io1_oe(io1_oe)
  );

  // ------------------------------------------------------------------
  // frame end detect
  // ------------------------------------------------------------------
  // the frame word is quiet once select is high and the link clock
  // stopped, so it is read only at the synced edge, two cycles after select rises
  assign end_frame = s_ff.cs_s2 & ~s_ff.cs_s3;
  assign new_frame = end_frame & (frame.tgl != s_ff.seen);
  assign pd_cmd = new_frame && frame.op == fmid_pkg::OP_PWR_DOWN &&
                  frame.clocks == fmid_pkg::CMD_BITS; // RULE1
  assign rel_cmd = new_frame && frame.op == fmid_pkg::OP_RELEASE &&
                   frame.clocks >= fmid_pkg::CMD_BITS;

  // ------------------------------------------------------------------
  // power state and busy
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.cs_s1 = spi_cs_n;
    nxt_s.cs_s2 = s_ff.cs_s1;
    nxt_s.cs_s3 = s_ff.cs_s2;
    if (end_frame)
      nxt_s.seen = frame.tgl;
    // a start in the same cycle as a done wins
    if (cyc_done)
      nxt_s.busy = 1'b0;
    if (cyc_start)
      nxt_s.busy = 1'b1; // RULE16
    case (s_ff.pwr)
      fmid_pkg::ST_RUN:
      begin
        if (pd_cmd && !s_ff.busy)
        begin
          nxt_s.pwr = fmid_pkg::ST_ENTER;
          nxt_s.tmr = fmid_pkg::TMR_W'(TDP_CYC - 1); // RULE2
        end
      end
      fmid_pkg::ST_ENTER:
      begin
        if (s_ff.tmr == '0)
          nxt_s.pwr = fmid_pkg::ST_DOWN;
        else
          nxt_s.tmr = s_ff.tmr - 1'b1;
      end
      fmid_pkg::ST_DOWN:
      begin
        if (rel_cmd)
        begin
          nxt_s.pwr = fmid_pkg::ST_WAKE;
          if (frame.clocks == fmid_pkg::CMD_BITS)
            nxt_s.tmr = fmid_pkg::TMR_W'(RES1_CYC - 1); // RULE5
          else
            nxt_s.tmr = fmid_pkg::TMR_W'(RES2_CYC - 1); // RULE8
        end
      end
      fmid_pkg::ST_WAKE:
      begin
        if (s_ff.tmr == '0)
          nxt_s.pwr = fmid_pkg::ST_RUN;
        else
          nxt_s.tmr = s_ff.tmr - 1'b1;
      end
      default: nxt_s.pwr = fmid_pkg::ST_RUN;
    endcase
    // link ignores all but release unless fully running
    nxt_s.gate = (nxt_s.pwr != fmid_pkg::ST_RUN);
  end

  // reset lands in normal operation, never powered down
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_ff <= '0; // RULE4
      s_ff.cs_s1 <= 1'b1;
      s_ff.cs_s2 <= 1'b1;
      s_ff.cs_s3 <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign busy = s_ff.busy;
  assign powered_down = (s_ff.pwr == fmid_pkg::ST_DOWN);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_pd_len;
    (new_frame && s_ff.pwr == fmid_pkg::ST_RUN &&
     frame.op == fmid_pkg::OP_PWR_DOWN &&
     frame.clocks != fmid_pkg::CMD_BITS) |=> s_ff.pwr == fmid_pkg::ST_RUN;
  endproperty
  a_pd_len: assert property (p_pd_len) // RULE1
    else $error("power-down taken with wrong bit count");

  property p_enter;
    $rose(s_ff.pwr == fmid_pkg::ST_ENTER)
      |-> ##[1:TDP_B] s_ff.pwr == fmid_pkg::ST_DOWN;
  endproperty
  a_enter: assert property (p_enter) // RULE2
    else $error("power-down entry too slow");

  property p_boot;
    $rose(reset_n) |-> s_ff.pwr == fmid_pkg::ST_RUN && !powered_down;
  endproperty
  a_boot: assert property (p_boot) // RULE4
    else $error("not in normal operation after reset");

  property p_wake;
    $rose(s_ff.pwr == fmid_pkg::ST_WAKE)
      |-> (s_ff.gate throughout ##[0:RESMAX_B] s_ff.tmr == '0)
      ##1 s_ff.pwr == fmid_pkg::ST_RUN;
  endproperty
  a_wake: assert property (p_wake) // RULE5
    else $error("release wait not bounded");

  property p_wake_id;
    (rel_cmd && s_ff.pwr == fmid_pkg::ST_DOWN &&
     frame.clocks > fmid_pkg::CMD_BITS)
      |=> s_ff.tmr == fmid_pkg::TMR_W'(RES2_CYC - 1);
  endproperty
  a_wake_id: assert property (p_wake_id) // RULE8
    else $error("id release used wrong wait");

  property p_busy;
    (cyc_start |=> busy) and (cyc_done && !cyc_start |=> !busy);
  endproperty
  a_busy: assert property (p_busy) // RULE16
    else $error("busy flag does not follow cycle");

  c_down: cover property (s_ff.pwr == fmid_pkg::ST_DOWN);
  c_wake: cover property (s_ff.pwr == fmid_pkg::ST_WAKE ##1
    s_ff.pwr == fmid_pkg::ST_RUN);

endmodule : fmid_top

// *** tb/fmid_host_model.sv ***
// Purpose: host side of the serial link, frames driven by task calls
// Assumes: link clock 12 ns, idle low, runs only inside frames
// Notes:   unused data lines toggle in the opcode and read phases so stale values never look valid
`timescale 1ns/100ps
module fmid_host_model
(
  // link pins
  output logic spi_sck,
  output logic spi_cs_n,
  output logic h_io0,
  output logic h_io1,
  // resolved wire levels
  input wire logic io0_i,
  input wire logic io1_i,
  input wire logic io1_oe
);
  logic seen_oe;

  // idle levels at time zero
  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    h_io0 = 1'b0;
    h_io1 = 1'b0;
    seen_oe = 1'b0;
  end

  // any drive of the serial output inside a frame
  always @(posedge io1_oe) seen_oe = 1'b1;

  // one link clock, data set up half a period before the rise
  task tick();
    #6 spi_sck = 1'b1;
    #6 spi_sck = 1'b0;
  endtask : tick

  // opcode, then n_in input clocks, then n_rd read clocks
  task frame(input logic [7:0] op, input int n_in, input logic [31:0] bits,
    input logic dual, input int n_rd, output logic [63:0] rd);
    int i;
    rd = 64'h0;
    seen_oe = 1'b0;
    #3 spi_cs_n = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      h_io0 = op[7-i];
      h_io1 = ~h_io1;
      tick();
    end
    for (i = 0; i < n_in; i++)
    begin
      if (dual)
        {h_io1, h_io0} = bits[2*(n_in-i)-1 -: 2];
      else
        h_io0 = bits[n_in-1-i];
      tick();
    end
    for (i = 0; i < n_rd; i++)
    begin
      h_io0 = ~h_io0;
      h_io1 = ~h_io1;
      #6 rd = dual ? {rd[61:0], io1_i, io0_i} : {rd[62:0], io1_i};
      spi_sck = 1'b1;
      #6 spi_sck = 1'b0;
    end
    // select rises right after the last clock, then stays high
    #6 spi_cs_n = 1'b1;
    #50;
  endtask : frame
endmodule : fmid_host_model

// *** tb/fmid_top_tb.sv ***
// Purpose: self-checking bench for power-down and id commands
// Assumes: wait times shortened to 10, 10 and 20 system cycles
// Notes:   id values below are arbitrary
`timescale 1ns/100ps
module fmid_top_tb;
  localparam logic [7:0] MFR = 8'hc3;
  localparam logic [7:0] DEV = 8'h4d;
  localparam logic [7:0] MEM = 8'h71;
  localparam logic [7:0] CAP = 8'h16;
  localparam logic [63:0] UID = 64'hfeed_0bad_1234_5678;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] n_in;
    logic [31:0] bits;
    logic dual;
    logic [7:0] n_rd;
    logic [63:0] exp;
  } fmid_row_s;
  logic clk, reset_n, cyc_start, cyc_done, busy, powered_down;
  logic spi_sck, spi_cs_n, h_io0, h_io1, io0_i, io1_i;
  logic io0_o, io0_oe, io1_o, io1_oe;
  logic [63:0] rd;
  int n_mismatch = 0;
  int checks = 0;
  fmid_row_s rows [0:6];

  // wire levels from all drivers
  assign io0_i = io0_oe ? io0_o : h_io0;
  assign io1_i = io1_oe ? io1_o : h_io1;

  fmid_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEM), .CAP_CODE(CAP),
    .UNIQUE_ID(UID), .T_DP_NS(100), .T_RES1_NS(100), .T_RES2_NS(200))
  i_fmid_top (.clk(clk), .reset_n(reset_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .io0_i(io0_i), .io1_i(io1_i), .io0_o(io0_o),
    .io0_oe(io0_oe), .io1_o(io1_o), .io1_oe(io1_oe), .cyc_start(cyc_start),
    .cyc_done(cyc_done), .busy(busy), .powered_down(powered_down));

  fmid_host_model i_fmid_host_model (.spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .h_io0(h_io0), .h_io1(h_io1), .io0_i(io0_i),
    .io1_i(io1_i), .io1_oe(io1_oe));

  // system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task chk_word(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk_word

  task chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {63'h0, exp}, {63'h0, got});
  endtask : chk_bit

  task run_row(input int i);
    i_fmid_host_model.frame(rows[i].op, int'(rows[i].n_in), rows[i].bits,
      rows[i].dual, int'(rows[i].n_rd), rd);
  endtask : run_row

  task simple(input logic [7:0] op, input int n_in, input int n_rd);
    i_fmid_host_model.frame(op, n_in, 32'h0, 1'b0, n_rd, rd);
  endtask : simple

  task finish_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // watchdog, far beyond the expected run of some 14 us
  initial
  begin
    #200000;
    $display("watchdog expired");
    n_mismatch++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    rows = '{
      '{8'hab, 8'd24, 32'h0, 1'b0, 8'd24, {40'h0, DEV, DEV, DEV}},
      '{8'h90, 8'd24, 32'h0, 1'b0, 8'd32, {32'h0, MFR, DEV, MFR, DEV}},
      '{8'h90, 8'd24, 32'h1, 1'b0, 8'd32, {32'h0, DEV, MFR, DEV, MFR}},
      '{8'h92, 8'd16, 32'hf0, 1'b1, 8'd16, {32'h0, MFR, DEV, MFR, DEV}},
      '{8'h92, 8'd16, 32'h1f0, 1'b1, 8'd16, {32'h0, DEV, MFR, DEV, MFR}},
      '{8'h4b, 8'd32, 32'h0, 1'b0, 8'd64, UID},
      '{8'h9f, 8'd0, 32'h0, 1'b0, 8'd32, {32'h0, MFR, MEM, CAP, MFR}}};
    reset_n = 1'b0;
    cyc_start = 1'b0;
    cyc_done = 1'b0;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    cyc(3);
    chk_bit("pd after reset", 1'b0, powered_down);
    chk_bit("busy after reset", 1'b0, busy);
    // table of id reads in normal operation
    for (int i = 0; i < 7; i++)
    begin
      run_row(i);
      chk_word("id stream", rows[i].exp, rd);
    end
    chk_bit("oe after select", 1'b0, io1_oe);
    $display("test id table done");
    // nine clocks: power-down must not execute
    simple(8'hb9, 1, 0);
    cyc(20);
    chk_bit("pd nine clocks", 1'b0, powered_down);
    simple(8'hb9, 0, 0);
    cyc(10);
    chk_bit("pd entered", 1'b1, powered_down);
    // every other read is ignored while down
    for (int i = 1; i < 7; i++)
    begin
      run_row(i);
      chk_bit("output while down", 1'b0, i_fmid_host_model.seen_oe);
    end
    simple(8'hab, 0, 0);
    cyc(14);
    chk_bit("pd released", 1'b0, powered_down);
    run_row(6);
    chk_word("id after release", rows[6].exp, rd);
    $display("test release done");
    // reset in mid-run while powered down
    simple(8'hb9, 0, 0);
    cyc(12);
    reset_n = 1'b0;
    cyc(3);
    reset_n = 1'b1;
    cyc(3);
    chk_bit("pd after second reset", 1'b0, powered_down);
    // release with id readout uses the longer wait
    simple(8'hb9, 0, 0);
    cyc(12);
    simple(8'hab, 24, 8);
    cyc(24);
    chk_bit("pd released with id", 1'b0, powered_down);
    run_row(6);
    chk_word("id after id release", rows[6].exp, rd);
    $display("test release with id done");
    // release opcode ignored during a program cycle
    cyc_start = 1'b1;
    cyc(1);
    cyc_start = 1'b0;
    cyc(1);
    simple(8'hab, 24, 8);
    chk_bit("output while busy", 1'b0, i_fmid_host_model.seen_oe);
    chk_bit("busy held", 1'b1, busy);
    cyc_done = 1'b1;
    cyc(1);
    cyc_done = 1'b0;
    cyc(2);
    chk_bit("busy cleared", 1'b0, busy);
    $display("test busy done");
    finish_test();
  end
endmodule : fmid_top_tb
